// >>> register_window_addressing.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "regwin_consts.svh"
// Operation
// [RULE_01] long-indexed address: base plus 16-bit displacement, unsigned
// [RULE_02] one long-indexed memory operand per instruction
// [RULE_03] first register word always reads zero
// [RULE_04] zero word as base gives absolute address
// [RULE_05] stack pointer lives at register 18h
// [RULE_06] 8-bit register address, 256 visible bytes
// [RULE_07] low seven bits map windows, top bit hold
// [RULE_08] horizontal windows 0, 1 and 15 only
// [RULE_09] horizontal window overlays lowest 24 bytes
// [RULE_10] horizontal contents reachable only through overlay
// [RULE_11] software writes zeros to bits 4-6 for horizontal
// [RULE_12] ram block overlays top 32/64/128 register bytes
// [RULE_13] bits 6/5/4 choose 32/64/128-byte windows
// [RULE_14] window bits join offset into 9-bit address
// [RULE_15] windowed ram also reachable by 16-bit address
// [RULE_16] status word pushed and popped as two bytes
// [RULE_17] flag byte has no register address
// [RULE_18] flag layout z n v vt c pse i st
// [RULE_19] zero result sets zero flag
// [RULE_20] carry/borrow ops only clear zero flag
// [RULE_21] trap set with overflow, cleared by trap ops
// [RULE_22] writes to zero word ignored
// [RULE_23] unwindowed registers unaffected by window select
module register_window_addressing #(
   parameter int RAM_AW = 9,
   parameter int RAM_DEPTH = 512
)
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // memory port by 16-bit address
   input wire logic [15:0] mem_addr_in,
   input wire logic [7:0] mem_wdata_in,
   input wire logic mem_wr_in,
   input wire logic mem_rd_in,
   output logic [7:0] mem_rdata_out,
   output logic mem_ext_out,
   // long-indexed address formation
   input wire logic idx_req_in,
   input wire logic [7:0] idx_base_reg_in,
   input wire logic [15:0] idx_base_val_in,
   input wire logic [15:0] idx_disp_in,
   input wire logic [1:0] idx_mem_refs_in,
   output logic [15:0] idx_addr_out,
   output logic idx_valid_out,
   output logic idx_reject_out,
   // flag update from arithmetic
   input wire logic [2:0] flag_op_in,
   input wire logic result_zero_in,
   input wire logic result_neg_in,
   input wire logic result_ovf_in,
   input wire logic result_carry_in,
   input wire logic result_sticky_in,
   input wire logic [7:0] pop_flags_in,
   input wire logic [7:0] pop_mask_in,
   output logic [7:0] program_status_flags_out,
   output logic [15:0] push_word_out,
   output logic bus_hold_enable_out,
   output logic [2:0] map_kind_out
);
   logic [7:0] register_window_select_q;
   logic [7:0] int_mask_q;
   logic [7:0] program_status_flags_q;
   logic [7:0] reg_rdata_q;
   logic mem_ext_q;
   logic [15:0] idx_addr_q;
   logic idx_valid_q;
   logic idx_reject_q;
   logic [2:0] map_kind_q;
   logic [7:0] flags_d;
   regwin_pkg::map_kind_e kind;
   logic [RAM_AW-1:0] ram_reg_addr;
   logic [RAM_AW-1:0] ram_mem_addr;
   logic ram_reg_we;
   logic ram_mem_we;
   logic [7:0] ram_reg_rdata;
   logic [7:0] ram_mem_rdata;
   logic hwin_sel0;
   logic hwin_sel1;
   logic hwin_sel15;
   logic [7:0] hwin_rdata0;
   logic [7:0] hwin_rdata1;
   logic [7:0] hwin_rdata15;
   logic [2:0] rd_src_q;
   logic [7:0] rd_low_q;
   logic mem_in_ram;
   logic [7:0] wsel_seen;

   localparam logic [2:0] SRC_RAM = 3'h0;
   localparam logic [2:0] SRC_LOW = 3'h1;
   localparam logic [2:0] SRC_H0 = 3'h2;
   localparam logic [2:0] SRC_H1 = 3'h3;
   localparam logic [2:0] SRC_H15 = 3'h4;

   // window select after a same-cycle write is not yet visible
   assign wsel_seen = register_window_select_q;

   // classify the register address under the current window
   always_comb
   begin
      kind = regwin_pkg::MAP_NORMAL;
      ram_reg_addr = {1'b0, reg_addr_in};
      hwin_sel0 = 1'b0;
      hwin_sel1 = 1'b0;
      hwin_sel15 = 1'b0;
      if (reg_addr_in <= `ZERO_WORD_HI_ADDR)
      begin
         kind = regwin_pkg::MAP_ZERO; // [RULE_03]
      end
      else if (wsel_seen[`WSEL_V32_BIT] && reg_addr_in >= `VWIN32_BASE)
      begin
         kind = regwin_pkg::MAP_VWIN; // [RULE_12] [RULE_13]
         ram_reg_addr = {wsel_seen[3:0], reg_addr_in[4:0]}; // [RULE_14]
      end
      else if (wsel_seen[`WSEL_V64_BIT] && reg_addr_in >= `VWIN64_BASE)
      begin
         kind = regwin_pkg::MAP_VWIN; // [RULE_13]
         ram_reg_addr = {wsel_seen[2:0], reg_addr_in[5:0]}; // [RULE_14]
      end
      else if (wsel_seen[`WSEL_V128_BIT] && reg_addr_in >= `VWIN128_BASE)
      begin
         kind = regwin_pkg::MAP_VWIN; // [RULE_13]
         ram_reg_addr = {wsel_seen[1:0], reg_addr_in[6:0]}; // [RULE_14]
      end
      else if (wsel_seen[6:4] == 3'h0 && wsel_seen[3:0] != `HWIN_NUM_0
               && reg_addr_in < `HWIN_BYTES)
      begin
         // [RULE_08] [RULE_09] unsupported numbers read as a hole
         kind = regwin_pkg::MAP_HWIN;
         hwin_sel1 = (wsel_seen[3:0] == `HWIN_NUM_1);
         hwin_sel15 = (wsel_seen[3:0] == `HWIN_NUM_15);
         if (!hwin_sel1 && !hwin_sel15)
         begin
            kind = regwin_pkg::MAP_HOLE;
         end
      end
      else if (reg_addr_in < `HWIN_BYTES)
      begin
         // window 0 holds the base special registers
         kind = regwin_pkg::MAP_HWIN;
         hwin_sel0 = 1'b1;
      end
      // [RULE_23] all else falls through to the normal file
   end

   // window-select lives in the window-0 low area; the mask has no register address
   assign ram_reg_we = reg_wr_in && (kind == regwin_pkg::MAP_NORMAL
                       || kind == regwin_pkg::MAP_VWIN); // [RULE_22]
   assign mem_in_ram = (mem_addr_in <= `RAM_TOP_ADDR);
   assign ram_mem_addr = mem_addr_in[RAM_AW-1:0];
   assign ram_mem_we = mem_wr_in && mem_in_ram; // [RULE_15]

   // shared storage for both paths
   regwin_ram #(
      .AW(RAM_AW),
      .DEPTH(RAM_DEPTH)
   ) u_ram (
      .clk_in(sys_clk_in),
      .a_addr_in(ram_reg_addr),
      .a_we_in(ram_reg_we),
      .a_wdata_in(reg_wdata_in),
      .a_rdata_out(ram_reg_rdata),
      .b_addr_in(ram_mem_addr),
      .b_we_in(ram_mem_we),
      .b_wdata_in(mem_wdata_in),
      .b_rdata_out(ram_mem_rdata)
   );

   // horizontal banks have no path but the overlay
   regwin_hwin #(.BYTES(24)) u_hwin0 (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .sel_in(hwin_sel0 && reg_addr_in != `WINDOW_SELECT_ADDR),
      .addr_in(reg_addr_in[4:0]),
      .we_in(reg_wr_in),
      .wdata_in(reg_wdata_in),
      .rdata_out(hwin_rdata0)
   ); // [RULE_10]
   regwin_hwin #(.BYTES(24)) u_hwin1 (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .sel_in(hwin_sel1),
      .addr_in(reg_addr_in[4:0]),
      .we_in(reg_wr_in),
      .wdata_in(reg_wdata_in),
      .rdata_out(hwin_rdata1)
   );
   regwin_hwin #(.BYTES(24)) u_hwin15 (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .sel_in(hwin_sel15),
      .addr_in(reg_addr_in[4:0]),
      .we_in(reg_wr_in),
      .wdata_in(reg_wdata_in),
      .rdata_out(hwin_rdata15)
   );

   // window select register
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         register_window_select_q <= `WINDOW_SELECT_RESET;
      end
      else if (reg_wr_in && reg_addr_in == `WINDOW_SELECT_ADDR)
      begin
         register_window_select_q <= reg_wdata_in; // [RULE_07] [RULE_11]
      end
   end

   // read-path source selection, data one cycle later
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_src_q <= SRC_LOW;
         rd_low_q <= 8'h00;
      end
      else if (reg_rd_in)
      begin
         rd_src_q <= SRC_LOW;
         rd_low_q <= 8'h00; // [RULE_03] [RULE_22]
         if (kind == regwin_pkg::MAP_NORMAL || kind == regwin_pkg::MAP_VWIN)
         begin
            rd_src_q <= SRC_RAM; // [RULE_06]
         end
         else if (hwin_sel0 && reg_addr_in == `WINDOW_SELECT_ADDR)
         begin
            rd_low_q <= register_window_select_q;
         end
         else if (hwin_sel0)
         begin
            rd_src_q <= SRC_H0;
         end
         else if (hwin_sel1)
         begin
            rd_src_q <= SRC_H1;
         end
         else if (hwin_sel15)
         begin
            rd_src_q <= SRC_H15;
         end
      end
   end

   // horizontal bank read captured in step with the ram
   logic [7:0] hwin_rd_q;
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         hwin_rd_q <= 8'h00;
      end
      else
      begin
         hwin_rd_q <= hwin_sel1 ? hwin_rdata1 :
                      hwin_sel15 ? hwin_rdata15 : hwin_rdata0;
      end
   end

   always_comb
   begin
      unique case (rd_src_q)
         SRC_RAM: reg_rdata_out = ram_reg_rdata;
         SRC_H0, SRC_H1, SRC_H15: reg_rdata_out = hwin_rd_q;
         default: reg_rdata_out = rd_low_q;
      endcase
   end

   // memory port: ram range inside, rest flagged external
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mem_ext_q <= 1'b0;
      end
      else
      begin
         mem_ext_q <= (mem_rd_in || mem_wr_in) && !mem_in_ram;
      end
   end
   assign mem_rdata_out = ram_mem_rdata;
   assign mem_ext_out = mem_ext_q;

   // long-indexed effective address
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         idx_addr_q <= 16'h0000;
         idx_valid_q <= 1'b0;
         idx_reject_q <= 1'b0;
      end
      else
      begin
         idx_valid_q <= 1'b0;
         idx_reject_q <= 1'b0;
         if (idx_req_in && idx_mem_refs_in > 2'h1)
         begin
            idx_reject_q <= 1'b1; // [RULE_02]
         end
         else if (idx_req_in)
         begin
            idx_valid_q <= 1'b1;
            if (idx_base_reg_in <= `ZERO_WORD_HI_ADDR)
            begin
               idx_addr_q <= idx_disp_in; // [RULE_04]
            end
            else
            begin
               // [RULE_01] [RULE_05] unsigned sum, wraps at 16 bits
               idx_addr_q <= idx_base_val_in + idx_disp_in;
            end
         end
      end
   end

   // flag byte update
   always_comb
   begin
      flags_d = program_status_flags_q;
      unique case (regwin_pkg::flag_op_e'(flag_op_in))
         regwin_pkg::OP_PLAIN, regwin_pkg::OP_ADD_CARRY,
         regwin_pkg::OP_SUB_BORROW:
         begin
            if (flag_op_in == 3'(regwin_pkg::OP_PLAIN))
            begin
               flags_d[`FLAG_Z_BIT] = result_zero_in; // [RULE_19]
            end
            else if (!result_zero_in)
            begin
               flags_d[`FLAG_Z_BIT] = 1'b0; // [RULE_20]
            end
            flags_d[`FLAG_N_BIT] = result_neg_in;
            flags_d[`FLAG_V_BIT] = result_ovf_in;
            flags_d[`FLAG_C_BIT] = result_carry_in;
            flags_d[`FLAG_ST_BIT] = result_sticky_in;
            if (result_ovf_in)
            begin
               flags_d[`FLAG_VT_BIT] = 1'b1; // [RULE_21]
            end
         end
         regwin_pkg::OP_CLEAR_TRAP, regwin_pkg::OP_JUMP_TRAP:
            flags_d[`FLAG_VT_BIT] = 1'b0; // [RULE_21]
         regwin_pkg::OP_POP_FLAGS:
            flags_d = pop_flags_in; // [RULE_16]
         default: flags_d = program_status_flags_q;
      endcase
   end

   // flag byte: no register address reaches it
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         program_status_flags_q <= `FLAGS_RESET;
      end
      else
      begin
         program_status_flags_q <= flags_d; // [RULE_17] [RULE_18]
      end
   end

   // interrupt-mask half of the status word
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         int_mask_q <= 8'h00;
      end
      else if (flag_op_in == 3'(regwin_pkg::OP_POP_FLAGS))
      begin
         int_mask_q <= pop_mask_in; // [RULE_16]
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         map_kind_q <= 3'h0;
      end
      else
      begin
         map_kind_q <= 3'(kind);
      end
   end

   assign program_status_flags_out = program_status_flags_q;
   assign push_word_out = {program_status_flags_q, int_mask_q}; // [RULE_16]
   assign bus_hold_enable_out = register_window_select_q[`WSEL_HOLD_BIT];
   assign idx_addr_out = idx_addr_q;
   assign idx_valid_out = idx_valid_q;
   assign idx_reject_out = idx_reject_q;
   assign map_kind_out = map_kind_q;
endmodule : register_window_addressing

// >>> regwin_consts.svh
`ifndef REGWIN_CONSTS_SVH
`define REGWIN_CONSTS_SVH
// register file offsets and window layout
`define WINDOW_SELECT_ADDR 8'h14
`define WINDOW_SELECT_RESET 8'h00
`define STACK_PTR_ADDR 8'h18
`define ZERO_WORD_HI_ADDR 8'h01
`define HWIN_BYTES 8'h18
`define HWIN_NUM_0 4'h0
`define HWIN_NUM_1 4'h1
`define HWIN_NUM_15 4'hf
`define WSEL_HOLD_BIT 7
`define WSEL_V32_BIT 6
`define WSEL_V64_BIT 5
`define WSEL_V128_BIT 4
`define VWIN32_BASE 8'he0
`define VWIN64_BASE 8'hc0
`define VWIN128_BASE 8'h80
`define RAM_TOP_ADDR 16'h01ff
`define FLAGS_RESET 8'h00
`define FLAG_Z_BIT 7
`define FLAG_N_BIT 6
`define FLAG_V_BIT 5
`define FLAG_VT_BIT 4
`define FLAG_C_BIT 3
`define FLAG_PSE_BIT 2
`define FLAG_I_BIT 1
`define FLAG_ST_BIT 0
`endif

// >>> regwin_pkg.sv
package regwin_pkg;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_PLAIN,
      OP_ADD_CARRY,
      OP_SUB_BORROW,
      OP_CLEAR_TRAP,
      OP_JUMP_TRAP,
      OP_POP_FLAGS
   } flag_op_e;
   typedef enum logic [2:0] {
      MAP_NORMAL,
      MAP_ZERO,
      MAP_HWIN,
      MAP_VWIN,
      MAP_HOLE
   } map_kind_e;
endpackage : regwin_pkg

// >>> regwin_ram.sv
`timescale 1ns/1ps
// two-port byte memory; port b is write-priority, both read registered
module regwin_ram #(
   parameter int AW = 9,
   parameter int DEPTH = 512
)
(
   input wire logic clk_in,
   input wire logic [AW-1:0] a_addr_in,
   input wire logic a_we_in,
   input wire logic [7:0] a_wdata_in,
   output logic [7:0] a_rdata_out,
   input wire logic [AW-1:0] b_addr_in,
   input wire logic b_we_in,
   input wire logic [7:0] b_wdata_in,
   output logic [7:0] b_rdata_out
);
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge clk_in)
   begin
      if (b_we_in)
      begin
         mem_q[b_addr_in] <= b_wdata_in;
      end
      else if (a_we_in)
      begin
         mem_q[a_addr_in] <= a_wdata_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      a_rdata_out <= mem_q[a_addr_in];
      b_rdata_out <= mem_q[b_addr_in];
   end
endmodule : regwin_ram

// >>> regwin_hwin.sv
`timescale 1ns/1ps
// one horizontal window bank of extra special registers
module regwin_hwin #(
   parameter int BYTES = 24
)
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic sel_in,
   input wire logic [4:0] addr_in,
   input wire logic we_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] bank_q [BYTES];

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < BYTES; i++)
         begin
            bank_q[i] <= 8'h00;
         end
      end
      else if (sel_in && we_in && (32'(addr_in) < BYTES))
      begin
         bank_q[addr_in] <= wdata_in;
      end
   end

   always_comb
   begin
      rdata_out = 8'h00;
      if (32'(addr_in) < BYTES)
      begin
         rdata_out = bank_q[addr_in];
      end
   end
endmodule : regwin_hwin

// >>> regwin_monitor.sv
`timescale 1ns/1ps
`include "regwin_consts.svh"
module regwin_monitor (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic idx_req_in,
   input wire logic [7:0] idx_base_reg_in,
   input wire logic [15:0] idx_base_val_in,
   input wire logic [15:0] idx_disp_in,
   input wire logic [1:0] idx_mem_refs_in,
   input wire logic [15:0] idx_addr_out,
   input wire logic idx_valid_out,
   input wire logic idx_reject_out,
   input wire logic [2:0] flag_op_in,
   input wire logic result_zero_in,
   input wire logic result_ovf_in,
   input wire logic [7:0] program_status_flags_out,
   input wire logic bus_hold_enable_out,
   input wire logic [2:0] map_kind_out
);
   logic [7:0] wsel_q;
   logic [8:0] vbase;
   logic hw;
   logic lo;
   logic idx_ok;
   // shadow of window select, written from any window
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         wsel_q <= `WINDOW_SELECT_RESET;
      else if (reg_wr_in && reg_addr_in == `WINDOW_SELECT_ADDR)
         wsel_q <= reg_wdata_in;
   end
   assign hw = wsel_q[6:4] == 3'h0;
   assign lo = reg_addr_in > `ZERO_WORD_HI_ADDR && reg_addr_in < `HWIN_BYTES;
   assign vbase = wsel_q[6] ? 9'h0e0 : wsel_q[5] ? 9'h0c0 :
                  wsel_q[4] ? 9'h080 : 9'h100;
   assign idx_ok = idx_req_in && idx_mem_refs_in < 2'd2;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   idx_sum_a: assert property (idx_ok && idx_base_reg_in > 8'h01 |=>
      idx_valid_out && idx_addr_out == $past(idx_base_val_in) + $past(idx_disp_in))
      else $error("indexed address is not base plus displacement");
   idx_abs_a: assert property (idx_ok && idx_base_reg_in <= 8'h01 |=>
      idx_valid_out && idx_addr_out == $past(idx_disp_in))
      else $error("zero base does not give absolute address");
   idx_rej_a: assert property (idx_req_in && idx_mem_refs_in > 2'd1 |=>
      idx_reject_out && !idx_valid_out)
      else $error("second memory operand not refused");
   zero_rd_a: assert property (reg_rd_in && reg_addr_in < 8'h02 |=>
      reg_rdata_out == 8'h00)
      else $error("zero word read nonzero");
   hold_bit_a: assert property (reg_wr_in && reg_addr_in == 8'h14 |=>
      bus_hold_enable_out == $past(reg_wdata_in[7]))
      else $error("hold enable does not follow select bit 7");
   vwin_map_a: assert property ({1'b0, reg_addr_in} >= vbase |=>
      map_kind_out == regwin_pkg::MAP_VWIN)
      else $error("top bytes not mapped to ram window");
   hwin_map_a: assert property (hw && lo && (wsel_q[3:0] == 4'h1 ||
      wsel_q[3:0] == 4'hf) |=> map_kind_out == regwin_pkg::MAP_HWIN)
      else $error("low bytes not mapped to horizontal window");
   hole_map_a: assert property (hw && lo && !(wsel_q[3:0] inside {4'h0, 4'h1,
      4'hf}) |=> map_kind_out == regwin_pkg::MAP_HOLE)
      else $error("unsupported horizontal window not empty");
   plain_map_a: assert property (reg_addr_in >= 8'h18 &&
      {1'b0, reg_addr_in} < vbase |=> map_kind_out == regwin_pkg::MAP_NORMAL)
      else $error("unwindowed register remapped");
   zflag_set_a: assert property (flag_op_in == regwin_pkg::OP_PLAIN |=>
      program_status_flags_out[7] == $past(result_zero_in))
      else $error("zero flag does not follow result");
   zflag_chain_a: assert property (flag_op_in inside {regwin_pkg::OP_ADD_CARRY,
      regwin_pkg::OP_SUB_BORROW} |=> program_status_flags_out[7] ==
      ($past(program_status_flags_out[7]) && $past(result_zero_in)))
      else $error("carry chain zero flag wrong");
   trap_set_a: assert property (flag_op_in == regwin_pkg::OP_PLAIN &&
      result_ovf_in |=> program_status_flags_out[5] && program_status_flags_out[4])
      else $error("overflow did not set trap");
   trap_hold_a: assert property ($fell(program_status_flags_out[4]) |->
      $past(flag_op_in) inside {regwin_pkg::OP_CLEAR_TRAP, regwin_pkg::OP_JUMP_TRAP,
      regwin_pkg::OP_POP_FLAGS})
      else $error("trap flag cleared by other operation");
   vwin_c: cover property (reg_rd_in && {1'b0, reg_addr_in} >= vbase);
   reject_c: cover property (idx_reject_out);
   trap_c: cover property ($fell(program_status_flags_out[4]));
endmodule : regwin_monitor
bind register_window_addressing regwin_monitor i_regwin_monitor (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .idx_req_in(idx_req_in),
   .idx_base_reg_in(idx_base_reg_in), .idx_base_val_in(idx_base_val_in),
   .idx_disp_in(idx_disp_in), .idx_mem_refs_in(idx_mem_refs_in),
   .idx_addr_out(idx_addr_out), .idx_valid_out(idx_valid_out),
   .idx_reject_out(idx_reject_out), .flag_op_in(flag_op_in),
   .result_zero_in(result_zero_in), .result_ovf_in(result_ovf_in),
   .program_status_flags_out(program_status_flags_out),
   .bus_hold_enable_out(bus_hold_enable_out), .map_kind_out(map_kind_out));

// >>> arith_unit_model.sv
`timescale 1ns/1ps
// register access side of the arithmetic unit
module arith_unit_model (
   input wire logic sys_clk_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out
);
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= w;
      reg_rd_out <= !w;
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      // released lines show the inverse, never the old value
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask : put
endmodule : arith_unit_model

// >>> tb.sv
`timescale 1ns/1ps
`include "regwin_consts.svh"
module tb;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] ra, rwd, rrd, flags, pop_f, pop_m, mwd, mrd, breg, ws, off, sp;
   logic rwr, rrdq, mwr, mrdq, mext, ireq, ival, irej, hold;
   logic r_z, r_n, r_v, r_c, r_s, rd_pend, mrd_pend;
   logic [15:0] maddr, bval, disp, iaddr, pushw, sum;
   logic [1:0] refs;
   logic [2:0] fop, mapk;
   logic [8:0] ram_a;
   logic [17:0] exp_q[$];
   logic [17:0] got;
   logic [31:0] r, q;
   int miscompares = 0, checks_done = 0, seed = 32'h18396ad5, cyc = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   arith_unit_model i_arith_unit_model (.sys_clk_in(sys_clk_in),
      .reg_addr_out(ra), .reg_wdata_out(rwd), .reg_wr_out(rwr), .reg_rd_out(rrdq));
   register_window_addressing i_register_window_addressing (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(ra),
      .reg_wdata_in(rwd), .reg_wr_in(rwr), .reg_rd_in(rrdq), .reg_rdata_out(rrd),
      .mem_addr_in(maddr), .mem_wdata_in(mwd), .mem_wr_in(mwr), .mem_rd_in(mrdq),
      .mem_rdata_out(mrd), .mem_ext_out(mext), .idx_req_in(ireq),
      .idx_base_reg_in(breg), .idx_base_val_in(bval), .idx_disp_in(disp),
      .idx_mem_refs_in(refs), .idx_addr_out(iaddr), .idx_valid_out(ival),
      .idx_reject_out(irej), .flag_op_in(fop), .result_zero_in(r_z),
      .result_neg_in(r_n), .result_ovf_in(r_v), .result_carry_in(r_c),
      .result_sticky_in(r_s), .pop_flags_in(pop_f), .pop_mask_in(pop_m),
      .program_status_flags_out(flags), .push_word_out(pushw),
      .bus_hold_enable_out(hold), .map_kind_out(mapk));
   task automatic chk(input logic [17:0] g, input logic [17:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_arith_unit_model.put(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({10'h000, e});
      i_arith_unit_model.put(1'b0, a, 8'h00);
   endtask : rd
   task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
      if (!w)
         exp_q.push_back({10'h100, d});
      @(posedge sys_clk_in);
      maddr <= a;
      mwd <= d;
      mwr <= w;
      mrdq <= !w;
      @(posedge sys_clk_in);
      mwr <= 1'b0;
      mrdq <= 1'b0;
   endtask : mem
   task automatic idx(input logic [7:0] b, input logic [15:0] v,
                      input logic [15:0] d, input logic [1:0] n);
      sum = (b <= 8'h01) ? d : v + d;
      exp_q.push_back(n > 2'd1 ? 18'h30000 : {2'd2, sum});
      @(posedge sys_clk_in);
      ireq <= 1'b1;
      breg <= b;
      bval <= v;
      disp <= d;
      refs <= n;
      @(posedge sys_clk_in);
      ireq <= 1'b0;
   endtask : idx
   task automatic flag(input logic [2:0] op, input logic [4:0] res);
      @(posedge sys_clk_in);
      fop <= op;
      {r_z, r_n, r_v, r_c, r_s} <= res;
      @(posedge sys_clk_in);
      fop <= regwin_pkg::OP_NONE;
   endtask : flag
   always @(posedge sys_clk_in)
   begin
      rd_pend <= rrdq;
      mrd_pend <= mrdq;
      cyc++;
      if (cyc > 20000)
      begin
         miscompares++;
         close_out();
      end
   end
   // result watcher: oldest note against each answer
   always @(negedge sys_clk_in)
   begin
      if (rd_pend === 1'b1 || mrd_pend === 1'b1 || ival === 1'b1 || irej === 1'b1)
      begin
         got = rd_pend ? {10'h000, rrd} : mrd_pend ? {10'h100, mrd} :
               irej ? 18'h30000 : {2'd2, iaddr};
         if (exp_q.size() == 0)
            chk(got, 18'h3ffff);
         else
            chk(got, exp_q.pop_front());
      end
   end
   initial
   begin
      {maddr, mwd, mwr, mrdq, ireq, breg, bval, disp, refs} = '0;
      {fop, r_z, r_n, r_v, r_c, r_s, pop_f, pop_m, rd_pend, mrd_pend} = '0;
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      r = $random(seed);
      sp = r[7:0];
      wr(8'h00, 8'ha5);
      wr(8'h01, 8'h5a);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      wr(`STACK_PTR_ADDR, sp);
      rd(`STACK_PTR_ADDR, sp);
      $display("zero word and stack pointer test done");
      for (int i = 0; i < 3; i++)
      begin
         r = $random(seed);
         q = $random(seed);
         ws = {r[7], (i == 0) ? 7'h49 : (i == 1) ? 7'h25 : 7'h13};
         off = {1'b0, r[14:8] & (7'h1f >> (2 - i) | 7'h1f << i)};
         case (i)
            0: ram_a = {ws[3:0], off[4:0]};
            1: ram_a = {ws[2:0], off[5:0]};
            default: ram_a = {ws[1:0], off[6:0]};
         endcase
         wr(`WINDOW_SELECT_ADDR, ws);
         wr(8'h00 - (8'h20 << i) + off, q[7:0]);
         mem(1'b0, {7'h00, ram_a}, q[7:0]);
         mem(1'b1, {7'h00, ram_a}, q[15:8]);
         rd(8'h00 - (8'h20 << i) + off, q[15:8]);
         rd(`STACK_PTR_ADDR, sp);
      end
      wr(`WINDOW_SELECT_ADDR, 8'h00);
      mem(1'b1, 16'h0200, 8'h00);
      @(negedge sys_clk_in);
      chk({17'h0, mext}, 18'h1);
      $display("vertical window test done");
      idx(8'h20, 16'hffff, 16'h0002, 2'd1);
      repeat (16)
      begin
         r = $random(seed);
         q = $random(seed);
         idx(r[3] ? r[15:8] : 8'h00, q[15:0], q[31:16], r[17:16]);
      end
      $display("indexed address test done");
      pop_f <= 8'h00;
      flag(regwin_pkg::OP_POP_FLAGS, 5'h00);
      flag(regwin_pkg::OP_PLAIN, 5'b01111);
      @(negedge sys_clk_in);
      chk({10'h000, flags}, 18'h00079);
      r = $random(seed);
      pop_f <= r[7:0];
      pop_m <= r[15:8];
      flag(regwin_pkg::OP_POP_FLAGS, 5'h00);
      repeat (2) @(negedge sys_clk_in);
      chk({2'd0, pushw}, {2'd0, r[7:0], r[15:8]});
      repeat (60)
      begin
         r = $random(seed);
         flag(r[2:0] % 3'd5 + 3'd1, r[8:4]);
      end
      $display("status flag test done");
      for (int i = 0; i < 3; i++)
      begin
         @(posedge sys_clk_in);
         rst_n_in <= 1'b0;
         repeat (3) @(posedge sys_clk_in);
         rst_n_in <= 1'b1;
         r = $random(seed);
         ws = {r[8], 3'b000, (i == 0) ? 4'h1 : (i == 1) ? 4'hf : 4'h3};
         wr(`STACK_PTR_ADDR, r[7:0]);
         wr(`WINDOW_SELECT_ADDR, ws);
         @(negedge sys_clk_in);
         chk({17'h0, hold}, {17'h0, r[8]});
         wr(8'h04, r[23:16]);
         rd(8'h04, (i == 2) ? 8'h00 : r[23:16]);
         rd(`STACK_PTR_ADDR, r[7:0]);
      end
      $display("horizontal window test done");
      for (int k = 0; k < 10 && exp_q.size() != 0; k++)
         @(posedge sys_clk_in);
      if (exp_q.size() != 0)
         miscompares++;
      close_out();
   end
endmodule : tb
